/* verilog/rvs_pkg.sv */
// constants and carrier types for the reset and vector start-up controller
package rvs_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_PEND  = 8'h04;
    localparam logic [7:0] ADDR_CAUSE = 8'h08;
    localparam logic [7:0] ADDR_FUSE  = 8'h0c;
    localparam logic [7:0] ADDR_STAT  = 8'h10;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int         NUM_IRQ     = 5;
    localparam int         CTRL_GIE    = 0;
    localparam int         CTRL_EN_LO  = 1;
    localparam int         CTRL_WDEN   = 8;
    localparam int         CAUSE_POR   = 0;
    localparam int         CAUSE_PIN   = 1;
    localparam int         CAUSE_WD    = 3;
    localparam logic [3:0] FUSE_RESET  = 4'h2;

    // ****************************************
    // vectors and timing counts
    // ****************************************
    localparam logic [9:0]  VEC_RESET    = 10'h000;
    localparam logic [9:0]  VEC_IRQ_BASE = 10'h001;
    localparam logic [15:0] CK_1K        = 16'h0400;
    localparam logic [15:0] CK_6         = 16'h0006;
    localparam logic [15:0] OSC_1K       = 16'h0400;
    localparam logic [3:0]  RESP_CYCLES  = 4'h4;
    localparam logic [3:0]  SLEEP_EXTRA  = 4'h4;

    typedef enum logic [2:0] {
        PH_HOLD = 3'b000,
        PH_WDP  = 3'b001,
        PH_MS   = 3'b010,
        PH_CK   = 3'b011,
        PH_RUN  = 3'b100,
        PH_WAKE = 3'b101
    } rvs_phase_t;

    typedef struct packed {
        logic por_low;     // supply below power-on level
        logic pin_n;       // external reset pin, low active
        logic wdt_expire;  // watchdog period expired, pulse
        logic osc_tick;    // one pulse per watchdog oscillator cycle
    } rvs_rst_src_t;

    typedef struct packed {
        logic instr_bound; // instruction boundary, pulse
        logic reti;        // return from interrupt, pulse
        logic asleep;      // core in sleep mode
        logic wake_pd;     // wake from power-down, pulse
    } rvs_core_t;

    typedef struct packed {
        rvs_phase_t         phase;
        logic [15:0]        cnt;
        logic               core_rst;
        logic               core_stall;
        logic               vec_req;
        logic [9:0]         vec_addr;
        logic               gie;
        logic [NUM_IRQ-1:0] en;
        logic               wden;
        logic [NUM_IRQ-1:0] pend;
        logic [3:0]         cause;
        logic [3:0]         fuse;
        logic               in_resp;
        logic [3:0]         resp_cnt;
        logic [2:0]         sel;
        logic [31:0]        prdata;
        logic               pready;
        logic               pslverr;
    } rvs_state_t;

endpackage

/* verilog/rvs_startup_ctrl.sv */
// reset merging, start-up delay and interrupt vector control with apb access
`timescale 1ns/1ps
`default_nettype none

module rvs_startup_ctrl #(
    parameter logic [15:0] CK_16K  = 16'h4000,
    parameter logic [15:0] CK_32K  = 16'h8000,
    parameter logic [15:0] OSC_16K = 16'h4000
) (
    input  wire  logic                        pclk,       // system clock
    input  wire  logic                        presetn,    // async reset
    input  wire  logic                        psel,       // apb select
    input  wire  logic                        penable,    // apb enable
    input  wire  logic                        pwrite,     // apb direction
    input  wire  logic [7:0]                  paddr,      // apb address
    input  wire  logic [31:0]                 pwdata,     // apb write data
    output logic [31:0]                       prdata,     // apb read data
    output logic                              pready,     // apb ready
    output logic                              pslverr,    // apb error
    input  wire  rvs_pkg::rvs_rst_src_t       rst_src,    // reset causes
    input  wire  rvs_pkg::rvs_core_t          core_in,    // core status
    input  wire  logic [rvs_pkg::NUM_IRQ-1:0] irq_set,    // source pulses
    output logic                              core_reset, // core held
    output logic                              core_stall, // wake delay
    output logic                              vec_req,    // load pc pulse
    output logic [9:0]                        vec_addr    // vector address
);

    rvs_pkg::rvs_state_t s_q;
    rvs_pkg::rvs_state_t s_d;
    logic                take_irq;
    logic                wd_fire;
    logic [2:0]          win;
    logic [rvs_pkg::NUM_IRQ-1:0] ready_irq;

    // ****************************************
    // start-up delay selection
    // ****************************************
    function automatic logic [15:0] ck_target(input logic [3:0] c);
        case (c)
            4'hf, 4'he, 4'hd, 4'h9: ck_target = rvs_pkg::CK_1K;
            4'hc, 4'hb, 4'ha:       ck_target = CK_16K;
            4'h8:                   ck_target = CK_32K;
            default:                ck_target = rvs_pkg::CK_6;
        endcase
    endfunction

    function automatic logic [15:0] ms_target(input logic [3:0] c);
        case (c)
            4'he, 4'hb, 4'h6, 4'h3, 4'h0:       ms_target = rvs_pkg::OSC_1K;
            4'hd, 4'ha, 4'h9, 4'h8, 4'h5, 4'h2: ms_target = OSC_16K;
            default:                            ms_target = 16'h0000;
        endcase
    endfunction

    // ****************************************
    // fixed priority: lowest index wins
    // ****************************************
    always_comb begin
        ready_irq = s_q.pend & s_q.en;
        win = 3'h0;
        for (int i = rvs_pkg::NUM_IRQ - 1; i >= 0; i--) begin
            if (ready_irq[i]) begin
                win = 3'(i);
            end
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d         = s_q;
        s_d.vec_req = 1'b0;
        s_d.pready  = 1'b0;
        s_d.pslverr = 1'b0;
        wd_fire     = rst_src.wdt_expire & s_q.wden &
                      (s_q.phase == rvs_pkg::PH_RUN ||
                       s_q.phase == rvs_pkg::PH_WAKE);
        take_irq    = 1'b0;

        // apb: answer in the cycle after setup, no wait states
        if (psel && !penable) begin
            s_d.pready = 1'b1;
            s_d.prdata = 32'h0000_0000;
            case (paddr)
                rvs_pkg::ADDR_CTRL: begin
                    s_d.prdata[rvs_pkg::CTRL_GIE] = s_q.gie;
                    s_d.prdata[rvs_pkg::CTRL_EN_LO +: rvs_pkg::NUM_IRQ] =
                        s_q.en;
                    s_d.prdata[rvs_pkg::CTRL_WDEN] = s_q.wden;
                end
                rvs_pkg::ADDR_PEND:  s_d.prdata[4:0] = s_q.pend;
                rvs_pkg::ADDR_CAUSE: s_d.prdata[3:0] = s_q.cause;
                rvs_pkg::ADDR_FUSE:  s_d.prdata[3:0] = s_q.fuse;
                rvs_pkg::ADDR_STAT:  s_d.prdata[7:0] =
                    {s_q.in_resp, s_q.core_stall, s_q.core_rst, 2'b00,
                     s_q.phase};
                default:             s_d.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && s_q.pready && pwrite) begin
            case (paddr)
                rvs_pkg::ADDR_CTRL: begin
                    s_d.gie  = pwdata[rvs_pkg::CTRL_GIE];
                    s_d.en   = pwdata[rvs_pkg::CTRL_EN_LO +:
                                      rvs_pkg::NUM_IRQ];
                    s_d.wden = pwdata[rvs_pkg::CTRL_WDEN];
                end
                rvs_pkg::ADDR_PEND:
                    s_d.pend = s_q.pend & ~pwdata[4:0];
                rvs_pkg::ADDR_CAUSE:
                    s_d.cause = s_q.cause & pwdata[3:0];
                rvs_pkg::ADDR_FUSE:  s_d.fuse = pwdata[3:0];
                default: ;
            endcase
        end

        // return re-arms the global enable
        if (core_in.reti) begin
            s_d.gie = 1'b1;
        end

        // interrupt response countdown
        if (s_q.in_resp) begin
            if (s_q.resp_cnt == 4'h1) begin
                s_d.in_resp  = 1'b0;
                s_d.vec_req  = 1'b1;
                s_d.vec_addr = rvs_pkg::VEC_IRQ_BASE +
                               {7'h00, s_q.sel};
            end else begin
                s_d.resp_cnt = s_q.resp_cnt - 4'h1;
            end
        end else if (s_q.phase == rvs_pkg::PH_RUN &&
                     core_in.instr_bound && s_q.gie &&
                     (|ready_irq)) begin
            take_irq     = 1'b1;
            s_d.in_resp  = 1'b1;
            s_d.sel      = win;
            s_d.gie      = 1'b0;
            s_d.pend[win] = 1'b0;
            s_d.resp_cnt = core_in.asleep ?
                           rvs_pkg::RESP_CYCLES + rvs_pkg::SLEEP_EXTRA -
                           4'h1 :
                           rvs_pkg::RESP_CYCLES - 4'h1;
        end

        // source pulses set flags after the write and vectoring clears, before the hold clear,
        // so an event landing in the take cycle is lost only to a reset
        s_d.pend = s_d.pend | irq_set;

        // reset sources override the phase sequence, restarting the delay
        if (rst_src.por_low) begin
            s_d.phase = rvs_pkg::PH_HOLD;
            s_d.cnt   = 16'h0000;
            s_d.cause = 4'h1 << rvs_pkg::CAUSE_POR;
        end else if (!rst_src.pin_n) begin
            s_d.phase = rvs_pkg::PH_HOLD;
            s_d.cnt   = 16'h0000;
            s_d.cause[rvs_pkg::CAUSE_PIN] = 1'b1;
        end else if (wd_fire) begin
            s_d.phase = rvs_pkg::PH_WDP;
            s_d.cnt   = 16'h0000;
            s_d.cause[rvs_pkg::CAUSE_WD] = 1'b1;
        end else begin
            case (s_q.phase)
                // pin released or supply up, or end of watchdog pulse
                rvs_pkg::PH_HOLD, rvs_pkg::PH_WDP: begin
                    s_d.cnt   = 16'h0000;
                    s_d.phase = (ms_target(s_q.fuse) != 16'h0000) ?
                                rvs_pkg::PH_MS : rvs_pkg::PH_CK;
                end
                rvs_pkg::PH_MS: begin
                    if (rst_src.osc_tick) begin
                        if (s_q.cnt + 16'h0001 >= ms_target(s_q.fuse)) begin
                            s_d.cnt   = 16'h0000;
                            s_d.phase = rvs_pkg::PH_CK;
                        end else begin
                            s_d.cnt = s_q.cnt + 16'h0001;
                        end
                    end
                end
                rvs_pkg::PH_CK, rvs_pkg::PH_WAKE: begin
                    if (s_q.cnt + 16'h0001 >= ck_target(s_q.fuse)) begin
                        s_d.cnt        = 16'h0000;
                        s_d.phase      = rvs_pkg::PH_RUN;
                        s_d.core_stall = 1'b0;
                        if (s_q.phase == rvs_pkg::PH_CK) begin
                            s_d.vec_req  = 1'b1;
                            s_d.vec_addr = rvs_pkg::VEC_RESET;
                        end
                    end else begin
                        s_d.cnt = s_q.cnt + 16'h0001;
                    end
                end
                rvs_pkg::PH_RUN: begin
                    if (core_in.wake_pd) begin
                        s_d.phase      = rvs_pkg::PH_WAKE;
                        s_d.core_stall = 1'b1;
                        s_d.cnt        = 16'h0000;
                    end
                end
                default: s_d.phase = rvs_pkg::PH_HOLD;
            endcase
        end

        s_d.core_rst = (s_d.phase == rvs_pkg::PH_HOLD ||
                        s_d.phase == rvs_pkg::PH_WDP  ||
                        s_d.phase == rvs_pkg::PH_MS   ||
                        s_d.phase == rvs_pkg::PH_CK);

        // while the core is held, control state returns to initial values
        if (s_d.core_rst) begin
            s_d.gie        = 1'b0;
            s_d.en         = '0;
            s_d.wden       = 1'b0;
            s_d.pend       = '0;
            s_d.in_resp    = 1'b0;
            s_d.resp_cnt   = 4'h0;
            s_d.core_stall = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q       <= '0;
            s_q.phase <= rvs_pkg::PH_HOLD;
            s_q.core_rst <= 1'b1;
            s_q.fuse  <= rvs_pkg::FUSE_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata     = s_q.prdata;
    assign pready     = s_q.pready;
    assign pslverr    = s_q.pslverr;
    assign core_reset = s_q.core_rst;
    assign core_stall = s_q.core_stall;
    assign vec_req    = s_q.vec_req;
    assign vec_addr   = s_q.vec_addr;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence wd_pulse_s;
        s_q.phase == rvs_pkg::PH_WDP ##1 s_q.phase != rvs_pkg::PH_WDP;
    endsequence

    sequence resp_wait_s;
        !vec_req [*3] ##1 vec_req;
    endsequence

    sequence resp_sleep_s;
        !vec_req [*7] ##1 vec_req;
    endsequence

    por_reassert_a: assert property (
        rst_src.por_low |=> core_reset && s_q.cnt == 16'h0000)
        else $error("supply drop did not reassert reset");

    pin_hold_a: assert property (
        !rst_src.pin_n |=> core_reset && s_q.phase == rvs_pkg::PH_HOLD)
        else $error("pin low did not hold reset");

    wd_pulse_a: assert property (
        wd_fire && !rst_src.por_low && rst_src.pin_n |=> wd_pulse_s)
        else $error("watchdog reset pulse not one cycle");

    release_vec_a: assert property (
        $fell(core_reset) |-> vec_req && vec_addr == 10'h000)
        else $error("release did not fetch from address zero");

    gie_clear_a: assert property (
        take_irq |=> !s_q.gie &&
        s_q.pend[$past(win)] == $past(irq_set[win]))
        else $error("vectoring left global enable or flag set");

    resp_time_a: assert property (
        take_irq && !core_in.asleep && !rst_src.por_low &&
        rst_src.pin_n |=> resp_wait_s)
        else $error("interrupt response not four cycles");

    prio_addr_a: assert property (
        take_irq && ready_irq[0] && !core_in.asleep && !rst_src.por_low &&
        rst_src.pin_n |-> ##4 vec_addr == 10'h001)
        else $error("highest priority source not served first");

    por_flags_a: assert property (
        rst_src.por_low |=> s_q.cause == 4'h1)
        else $error("power-on did not set only its own flag");

    take_gate_a: assert property (
        take_irq |=> $past(s_q.gie) && $past(s_q.en[win]) &&
        $past(s_q.pend[win]))
        else $error("interrupt taken without enables");

    resp_sleep_a: assert property (
        take_irq && core_in.asleep && !rst_src.por_low &&
        rst_src.pin_n |=> resp_sleep_s)
        else $error("interrupt response from sleep not eight cycles");

    pend_keep_a: assert property (
        (|irq_set) && !core_reset && !rst_src.por_low && rst_src.pin_n &&
        !wd_fire |=> (s_q.pend & $past(irq_set)) == $past(irq_set))
        else $error("source event lost from pending flags");

    wake_stall_a: assert property (
        s_q.phase == rvs_pkg::PH_RUN && core_in.wake_pd &&
        !rst_src.por_low && rst_src.pin_n && !wd_fire |=>
        core_stall && !core_reset)
        else $error("power-down wake did not stall only");

endmodule

`default_nettype wire

/* bench/rvs_core_model.sv */
// behavioural processor core that runs code and fetches vectors
`timescale 1ns/1ps
`default_nettype none

module rvs_core_model (
    input  wire logic             pclk,       // system clock
    input  wire logic             presetn,    // async reset
    input  wire logic             core_reset, // core held in reset
    input  wire logic             vec_req,    // load pc pulse
    input  wire logic [9:0]       vec_addr,   // vector address
    input  wire logic             bound_en,   // execute instructions
    input  wire logic             sleep_i,    // core asleep
    input  wire logic             wake_i,     // power-down wake request
    output var rvs_pkg::rvs_core_t core_in    // status to controller
);
    logic [1:0] ret_q;

    // handler is short: it returns three cycles after the vector load
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_in <= '0;
            ret_q   <= 2'h0;
        end else begin
            core_in.instr_bound <= bound_en & ~core_reset;
            core_in.asleep      <= sleep_i;
            core_in.wake_pd     <= wake_i;
            core_in.reti        <= (ret_q == 2'h1);
            if (vec_req && vec_addr != 10'h000) begin
                ret_q <= 2'h3;
            end else if (ret_q != 2'h0) begin
                ret_q <= ret_q - 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* bench/rvs_startup_ctrl_tb.sv */
// self-checking bench for the reset and vector start-up controller
`timescale 1ns/1ps
`default_nettype none

module rvs_startup_ctrl_tb;
    localparam logic [15:0] C16 = 16'h0010;
    localparam logic [15:0] C32 = 16'h0020;
    logic                 pclk, presetn, psel, penable, pwrite, pready;
    logic                 pslverr, core_reset, core_stall, vec_req;
    logic                 bound_en, sleep_i, wake_i;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [4:0]           irq_set;
    logic [9:0]           vec_addr;
    logic                 e;
    rvs_pkg::rvs_rst_src_t rst_src;
    rvs_pkg::rvs_core_t   core_in;
    int                   miscompares, total_checks, vcnt, n;

    rvs_startup_ctrl #(.CK_16K(C16), .CK_32K(C32), .OSC_16K(C16)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rst_src(rst_src),
        .core_in(core_in), .irq_set(irq_set), .core_reset(core_reset),
        .core_stall(core_stall), .vec_req(vec_req), .vec_addr(vec_addr));

    rvs_core_model core (
        .pclk(pclk), .presetn(presetn), .core_reset(core_reset),
        .vec_req(vec_req), .vec_addr(vec_addr), .bound_en(bound_en),
        .sleep_i(sleep_i), .wake_i(wake_i), .core_in(core_in));

    always #5 pclk = ~pclk;

    always @(posedge pclk) begin
        if (vec_req === 1'b1) begin
            vcnt++;
        end
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic end_of_test();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string w, input logic [31:0] x,
                       input logic [31:0] g);
        total_checks++;
        if (g !== x) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", w, x, g);
        end
    endtask

    task automatic step(input int c);
        repeat (c) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // idle edge, so a following setup never reassigns psel at once
        @(posedge pclk);
        chk("apb answer", 1, k < 50);
        if (k >= 50) begin
            end_of_test();
        end
    endtask

    // s: 0 core out of reset, 1 vector load, 2 wake stall
    task automatic wait_for(input int s);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!((s == 0 && core_reset === 1'b0) ||
                     (s == 1 && vec_req === 1'b1) ||
                     (s == 2 && core_stall === 1'b1)) && n < 20000);
        if (n >= 20000) begin
            chk("wait bound", s, 32'hffff_ffff);
            end_of_test();
        end
    endtask

    // expected edges from release to seeing the core out of reset:
    // one for the hold phase to see the release, one for the register
    function automatic int dly(input logic [3:0] f);
        int ms, ck;
        ms = (f inside {4'he, 4'hb, 4'h6, 4'h3, 4'h0}) ? 1024 :
             (f inside {4'hd, 4'ha, 4'h9, 4'h8, 4'h5, 4'h2}) ? int'(C16) : 0;
        ck = (f >= 4'hd || f == 4'h9) ? 1024 : (f >= 4'ha) ? int'(C16) :
             (f == 4'h8) ? int'(C32) : 6;
        return ms + ck + 2;
    endfunction

    // ****************************************
    // scenarios
    // ****************************************
    task automatic startup(input logic [3:0] f);
        apb(1'b1, rvs_pkg::ADDR_FUSE, {28'h0, f});
        rst_src.pin_n <= 1'b0;
        step(2);
        chk("core_reset on pin", 1, core_reset);
        rst_src.pin_n <= 1'b1;
        wait_for(0);
        chk("start-up edges", dly(f), n);
        chk("reset vector load", 1, vec_req);
        chk("reset vector", 0, vec_addr);
    endtask

    task automatic por_case();
        rst_src.por_low <= 1'b1;
        step(2);
        chk("core_reset on supply", 1, core_reset);
        apb(1'b1, rvs_pkg::ADDR_CTRL, 32'h0000_003f);
        rst_src.por_low <= 1'b0;
        wait_for(0);
        chk("supply edges", dly(4'h0), n);
        apb(1'b0, rvs_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl after reset", 0, rd);
        apb(1'b0, rvs_pkg::ADDR_CAUSE, 32'h0);
        chk("cause after supply", 1, rd);
        apb(1'b1, rvs_pkg::ADDR_CAUSE, 32'h0);
        apb(1'b1, rvs_pkg::ADDR_CTRL, 32'h0000_0100);
        rst_src.wdt_expire <= 1'b1;
        step(1);
        rst_src.wdt_expire <= 1'b0;
        step(1);
        chk("core_reset on watchdog", 1, core_reset);
        wait_for(0);
        chk("watchdog vector", 0, vec_addr);
        apb(1'b0, rvs_pkg::ADDR_CAUSE, 32'h0);
        chk("cause after watchdog", 32'h8, rd);
    endtask

    task automatic restart_case();
        int v;
        apb(1'b1, rvs_pkg::ADDR_FUSE, 32'h7);
        rst_src.pin_n <= 1'b0;
        step(2);
        rst_src.pin_n <= 1'b1;
        step(3);
        rst_src.pin_n <= 1'b0;
        step(1);
        rst_src.pin_n <= 1'b1;
        wait_for(0);
        chk("restart edges", dly(4'h7), n);
        apb(1'b1, rvs_pkg::ADDR_FUSE, 32'h6);
        v = vcnt;
        wake_i <= 1'b1;
        step(1);
        wake_i <= 1'b0;
        wait_for(2);
        n = 1;
        while (n < 100 && core_stall !== 1'b0) begin
            step(1);
            n += (core_stall === 1'b1);
            if (core_stall !== 1'b1) break;
        end
        chk("wake stall", 6, n);
        chk("no vector on wake", v, vcnt);
    endtask

    task automatic irq_case();
        int v;
        apb(1'b1, rvs_pkg::ADDR_CTRL, 32'h0000_003e);
        irq_set <= 5'h1f;
        step(1);
        irq_set <= 5'h00;
        v = vcnt;
        step(8);
        chk("no vector without gie", v, vcnt);
        apb(1'b0, rvs_pkg::ADDR_PEND, 32'h0);
        chk("pending", 32'h1f, rd);
        apb(1'b1, rvs_pkg::ADDR_CTRL, 32'h0000_003f);
        wait_for(1);
        // the take falls on the idle edge that ends the enabling write
        chk("response edges", {28'h0, rvs_pkg::RESP_CYCLES}, n);
        for (int i = 1; i <= 5; i++) begin
            if (i > 1) wait_for(1);
            chk("vector order", i, vec_addr);
        end
        apb(1'b0, rvs_pkg::ADDR_PEND, 32'h0);
        chk("pending served", 0, rd);
        apb(1'b1, rvs_pkg::ADDR_CTRL, 32'h0000_0021);
        irq_set <= 5'h01;
        step(1);
        irq_set <= 5'h00;
        v = vcnt;
        step(8);
        chk("no vector when disabled", v, vcnt);
        sleep_i <= 1'b1;
        step(2);
        apb(1'b1, rvs_pkg::ADDR_CTRL, 32'h0000_003f);
        wait_for(1);
        chk("sleep response edges",
            {28'h0, rvs_pkg::RESP_CYCLES + rvs_pkg::SLEEP_EXTRA}, n);
        chk("sleep vector", 1, vec_addr);
        sleep_i <= 1'b0;
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped error", 1, e);
        chk("unmapped data", 0, rd);
    endtask

    initial begin
        pclk    = 1'b0;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        rst_src = '{por_low: 1'b0, pin_n: 1'b1, wdt_expire: 1'b0,
                    osc_tick: 1'b1};
        irq_set  = 5'h00;
        bound_en = 1'b1;
        sleep_i  = 1'b0;
        wake_i   = 1'b0;
        step(8);
        presetn <= 1'b1;
        wait_for(0);
        chk("power-up edges", dly(rvs_pkg::FUSE_RESET), n);
        apb(1'b0, rvs_pkg::ADDR_FUSE, 32'h0);
        chk("fuse default", 32'h2, rd);
        for (int f = 15; f >= 0; f--) begin
            startup(f[3:0]);
        end
        por_case();
        restart_case();
        irq_case();
        end_of_test();
    end
endmodule
`default_nettype wire
